/* File: pkg/ptlec_map.vh */
// Offsets, field positions, reset values and counts of the test loop and error tally block
`ifndef PTLEC_MAP_VH
`define PTLEC_MAP_VH

// Management register word offsets
`define PTLEC_ADDR_CTRL_ONE     5'h13
`define PTLEC_ADDR_ERR_TALLY    5'h15
`define PTLEC_ADDR_TF_CONTROL   5'h1C
`define PTLEC_ADDR_TF_CONTENT   5'h1D

// transceiver_control_one fields
`define PTLEC_LOOP_LSB          0
`define PTLEC_LOOP_MSB          2

// error_tally fields
`define PTLEC_COUNT_LSB         0
`define PTLEC_COUNT_MSB         7
`define PTLEC_SEL_LSB           8
`define PTLEC_SEL_MSB           10
`define PTLEC_COUNT_MAX         8'hFF

// test_frame_control fields
`define PTLEC_TF_ENABLE_BIT     0
`define PTLEC_TF_LEN_LSB        8
`define PTLEC_TF_LEN_MSB        15

// Reset values
`define PTLEC_RST_WORD          16'h0000
`define PTLEC_RST_LEN           8'h40
`define PTLEC_RST_CONTENT       16'h00A5

// Test loop selector codes
`define PTLEC_LOOP_NONE         3'h0
`define PTLEC_LOOP_NEAR         3'h1
`define PTLEC_LOOP_CONNECTOR    3'h2
`define PTLEC_LOOP_ECHO         3'h3
`define PTLEC_LOOP_FAR          3'h4

// Frame layout counts, in octets, and the preamble and delimiter octet values
`define PTLEC_PREAMBLE_LEN      4'h7
`define PTLEC_GAP_LEN           4'hC
`define PTLEC_PREAMBLE_OCTET    8'h55
`define PTLEC_SFD_OCTET         8'hD5

`endif

/* File: hdl/ptlec_fifo.v */
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module ptlec_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk_sys_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire             out_valid_o,
    input  wire             out_ready_i
);
    reg  [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr_reg;
    reg  [AW-1:0]    rd_ptr_reg;
    reg  [AW:0]      count_reg;
    wire             push;
    wire             pop;

    assign in_ready_o  = (count_reg != DEPTH[AW:0]);
    assign out_valid_o = (count_reg != {(AW+1){1'b0}});
    assign out_data_o  = mem_reg[rd_ptr_reg];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always @(posedge clk_sys_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

/* File: hdl/ptlec_top.v */
// Test frame source, error tally and test loop selection of a twisted-pair transceiver
`timescale 1ns/1ps
`include "ptlec_map.vh"
module ptlec_top (
    input  wire        clk_sys_i,
    input  wire        rst_i,
    input  wire [4:0]  mgmt_addr_i,
    input  wire        mgmt_wr_i,
    input  wire        mgmt_rd_i,
    input  wire [15:0] mgmt_wdata_i,
    output reg  [15:0] mgmt_rdata_o,
    output reg         mgmt_rvalid_o,
    input  wire        standard_loopback_bit_i,
    input  wire        speed_select_high_i,
    input  wire        speed_select_low_i,
    input  wire        tp_mode_i,
    input  wire        link_up_i,
    input  wire [7:0]  err_event_i,
    input  wire [7:0]  mac_txd_i,
    input  wire        mac_tx_en_i,
    input  wire        mac_tx_er_i,
    output reg  [7:0]  mac_rxd_o,
    output reg         mac_rx_dv_o,
    output reg         mac_rx_er_o,
    input  wire [7:0]  line_rxd_i,
    input  wire        line_rx_dv_i,
    input  wire        line_rx_er_i,
    output reg  [7:0]  line_txd_o,
    output reg         line_tx_en_o,
    output reg         line_tx_er_o,
    input  wire        line_tx_ready_i,
    output reg         connector_loop_o,
    output reg         echo_loop_o,
    output reg         far_end_loop_o,
    output reg         mac_loop_o
);
    // Test frame source states
    localparam ST_IDLE = 3'h0;
    localparam ST_PRE  = 3'h1;
    localparam ST_SFD  = 3'h2;
    localparam ST_DATA = 3'h3;
    localparam ST_GAP  = 3'h4;

    // Selects one error source out of the event vector
    function pick_event;
        input [7:0] events;
        input [2:0] sel;
        begin
            pick_event = events[sel];
        end
    endfunction

    // Tells whether the active loop equals a given code
    function loop_is;
        input [2:0] active;
        input [2:0] code;
        begin
            loop_is = (active == code);
        end
    endfunction

    reg  [2:0]  loop_pending_reg;
    reg  [2:0]  loop_active_reg;
    reg         loop_armed_reg;
    reg         link_prev_reg;
    reg  [7:0]  count_reg;
    reg  [7:0]  count_next;
    reg  [2:0]  err_sel_reg;
    reg         tf_enable_reg;
    reg  [7:0]  tf_len_reg;
    reg  [15:0] tf_content_reg;
    reg  [2:0]  tf_state_reg;
    reg  [2:0]  tf_state_next;
    reg  [7:0]  tf_cnt_reg;
    reg  [7:0]  tf_cnt_next;
    reg  [7:0]  tf_octet;
    reg         tf_valid;
    reg  [9:0]  fifo_in_data;
    reg         fifo_in_valid;
    wire        fifo_in_ready;
    wire [9:0]  fifo_out_data;
    wire        fifo_out_valid;
    wire        link_rise;
    wire        mac_loop_now;
    wire        far_loop_now;
    wire        rd_tally;
    wire        err_hit;

    // A link already up at reset release reads as a rise; nothing is armed yet
    assign link_rise    = link_up_i && !link_prev_reg;
    // Standard bit acts at once; the near-end code waits for a link-up
    assign mac_loop_now = standard_loopback_bit_i ||
                          loop_is(loop_active_reg, `PTLEC_LOOP_NEAR);
    // Far-end loop drops with the link at once; the code stays active for later
    assign far_loop_now = loop_is(loop_active_reg, `PTLEC_LOOP_FAR) && link_up_i;
    assign rd_tally     = mgmt_rd_i && (mgmt_addr_i == `PTLEC_ADDR_ERR_TALLY);
    assign err_hit      = tp_mode_i && pick_event(err_event_i, err_sel_reg);

    // Loop selection staging and activation at link-up
    // A write on the link-up edge re-arms, so the new code waits for the next rise
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            loop_pending_reg <= `PTLEC_LOOP_NONE;
            loop_active_reg  <= `PTLEC_LOOP_NONE;
            loop_armed_reg   <= 1'b0;
            link_prev_reg    <= 1'b0;
        end else begin
            link_prev_reg <= link_up_i;
            if (mgmt_wr_i && (mgmt_addr_i == `PTLEC_ADDR_CTRL_ONE)) begin
                loop_pending_reg <= mgmt_wdata_i[`PTLEC_LOOP_MSB:`PTLEC_LOOP_LSB];
                loop_armed_reg   <= 1'b1;
            end else if (link_rise && loop_armed_reg) begin
                loop_active_reg <= loop_pending_reg;
                loop_armed_reg  <= 1'b0;
            end
        end
    end

    // Saturating tally; an event in the clearing cycle counts as one
    // Holding at the top avoids a wrapped count that would look small
    always @* begin
        count_next = count_reg;
        if (rd_tally) begin
            count_next = err_hit ? 8'h01 : 8'h00;
        end else if (err_hit && (count_reg != `PTLEC_COUNT_MAX)) begin
            count_next = count_reg + 8'h01;
        end
    end

    // Management registers
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            count_reg      <= 8'h00;
            err_sel_reg    <= 3'h0;
            tf_enable_reg  <= 1'b0;
            tf_len_reg     <= `PTLEC_RST_LEN;
            tf_content_reg <= `PTLEC_RST_CONTENT;
            mgmt_rdata_o   <= `PTLEC_RST_WORD;
            mgmt_rvalid_o  <= 1'b0;
        end else begin
            count_reg     <= count_next;
            mgmt_rvalid_o <= mgmt_rd_i;
            if (mgmt_wr_i) begin
                case (mgmt_addr_i)
                    `PTLEC_ADDR_ERR_TALLY: begin
                        err_sel_reg <= mgmt_wdata_i[`PTLEC_SEL_MSB:`PTLEC_SEL_LSB];
                    end
                    `PTLEC_ADDR_TF_CONTROL: begin
                        tf_enable_reg <= mgmt_wdata_i[`PTLEC_TF_ENABLE_BIT];
                        tf_len_reg    <= mgmt_wdata_i[`PTLEC_TF_LEN_MSB:`PTLEC_TF_LEN_LSB];
                    end
                    `PTLEC_ADDR_TF_CONTENT: begin
                        tf_content_reg <= mgmt_wdata_i;
                    end
                    default: begin
                    end
                endcase
            end
            if (mgmt_rd_i) begin
                case (mgmt_addr_i)
                    // Reads back the pending code, not the active one
                    `PTLEC_ADDR_CTRL_ONE: begin
                        mgmt_rdata_o <= {13'h0000, loop_pending_reg};
                    end
                    `PTLEC_ADDR_ERR_TALLY: begin
                        mgmt_rdata_o <= {5'h00, err_sel_reg, count_reg};
                    end
                    `PTLEC_ADDR_TF_CONTROL: begin
                        mgmt_rdata_o <= {tf_len_reg, 7'h00, tf_enable_reg};
                    end
                    `PTLEC_ADDR_TF_CONTENT: begin
                        mgmt_rdata_o <= tf_content_reg;
                    end
                    default: begin
                        mgmt_rdata_o <= `PTLEC_RST_WORD;
                    end
                endcase
            end
        end
    end

    // Test frame source: preamble, delimiter, payload octets, gap; stalls on the FIFO
    always @* begin
        tf_state_next = tf_state_reg;
        tf_cnt_next   = tf_cnt_reg;
        tf_octet      = 8'h00;
        tf_valid      = 1'b0;
        case (tf_state_reg)
            ST_IDLE: begin
                if (tf_enable_reg) begin
                    tf_state_next = ST_PRE;
                    tf_cnt_next   = 8'h00;
                end
            end
            ST_PRE: begin
                tf_octet = `PTLEC_PREAMBLE_OCTET;
                tf_valid = 1'b1;
                if (fifo_in_ready) begin
                    tf_cnt_next = tf_cnt_reg + 8'h01;
                    if (tf_cnt_reg == {4'h0, `PTLEC_PREAMBLE_LEN} - 8'h01) begin
                        tf_state_next = ST_SFD;
                    end
                end
            end
            ST_SFD: begin
                tf_octet = `PTLEC_SFD_OCTET;
                tf_valid = 1'b1;
                if (fifo_in_ready) begin
                    tf_state_next = ST_DATA;
                    tf_cnt_next   = 8'h00;
                end
            end
            ST_DATA: begin
                // Payload alternates low and high content octets
                tf_octet = tf_cnt_reg[0] ? tf_content_reg[15:8] : tf_content_reg[7:0];
                tf_valid = 1'b1;
                if (fifo_in_ready) begin
                    tf_cnt_next = tf_cnt_reg + 8'h01;
                    if (tf_cnt_reg + 8'h01 >= tf_len_reg) begin
                        tf_state_next = ST_GAP;
                        tf_cnt_next   = 8'h00;
                    end
                end
            end
            ST_GAP: begin
                // Gap entries carry enable low, so the line idles
                if (fifo_in_ready) begin
                    tf_cnt_next = tf_cnt_reg + 8'h01;
                    if (tf_cnt_reg == {4'h0, `PTLEC_GAP_LEN} - 8'h01) begin
                        tf_state_next = ST_IDLE;
                    end
                end
            end
            default: begin
                tf_state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            tf_state_reg <= ST_IDLE;
            tf_cnt_reg   <= 8'h00;
        end else begin
            tf_state_reg <= tf_state_next;
            tf_cnt_reg   <= tf_cnt_next;
        end
    end

    // Line transmit source selection; MAC data cannot stall, so it is lost if the FIFO is full
    always @* begin
        fifo_in_data  = {mac_tx_er_i, mac_tx_en_i, mac_txd_i};
        fifo_in_valid = 1'b1;
        if (mac_loop_now) begin
            fifo_in_data  = 10'h000;
            fifo_in_valid = 1'b1;
        end else if (far_loop_now) begin
            fifo_in_data  = {line_rx_er_i, line_rx_dv_i, line_rxd_i};
            fifo_in_valid = 1'b1;
        end else if (tf_enable_reg || (tf_state_reg != ST_IDLE)) begin
            fifo_in_data  = {1'b0, tf_valid, tf_octet};
            fifo_in_valid = 1'b1;
        end
    end

    // Four entries absorb source stalls against sink back-pressure
    ptlec_fifo #(
        .WIDTH (10),
        .DEPTH (4),
        .AW    (2)
    ) u_tx_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .in_data_i   (fifo_in_data),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fifo_out_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (line_tx_ready_i)
    );

    // Registered line and MAC side outputs
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            line_txd_o       <= 8'h00;
            line_tx_en_o     <= 1'b0;
            line_tx_er_o     <= 1'b0;
            mac_rxd_o        <= 8'h00;
            mac_rx_dv_o      <= 1'b0;
            mac_rx_er_o      <= 1'b0;
            connector_loop_o <= 1'b0;
            echo_loop_o      <= 1'b0;
            far_end_loop_o   <= 1'b0;
            mac_loop_o       <= 1'b0;
        end else begin
            // Entries still drain under the standard loopback but never reach the line
            if (fifo_out_valid && line_tx_ready_i && !standard_loopback_bit_i) begin
                line_txd_o   <= fifo_out_data[7:0];
                line_tx_en_o <= fifo_out_data[8];
                line_tx_er_o <= fifo_out_data[9];
            end else begin
                line_txd_o   <= 8'h00;
                line_tx_en_o <= 1'b0;
                line_tx_er_o <= 1'b0;
            end
            if (mac_loop_now) begin
                mac_rxd_o   <= mac_txd_i;
                mac_rx_dv_o <= mac_tx_en_i;
                mac_rx_er_o <= mac_tx_er_i;
            end else begin
                mac_rxd_o   <= line_rxd_i;
                mac_rx_dv_o <= line_rx_dv_i;
                mac_rx_er_o <= line_rx_er_i;
            end
            mac_loop_o       <= mac_loop_now;
            connector_loop_o <= loop_is(loop_active_reg, `PTLEC_LOOP_CONNECTOR);
            // Canceller training and replica feed-back happen in the attachment on this flag
            echo_loop_o      <= loop_is(loop_active_reg, `PTLEC_LOOP_ECHO) &&
                                speed_select_high_i && !speed_select_low_i &&
                                tp_mode_i;
            far_end_loop_o   <= far_loop_now;
        end
    end
endmodule

/* File: sim/ptlec_monitor.sv */
// Port checker of the test loop and error tally block
`timescale 1ns/1ps
module ptlec_monitor (
    input wire        clk_sys_i,
    input wire        rst_i,
    input wire        mgmt_rd_i,
    input wire [15:0] mgmt_rdata_o,
    input wire        mgmt_rvalid_o,
    input wire        standard_loopback_bit_i,
    input wire        speed_select_high_i,
    input wire        speed_select_low_i,
    input wire        tp_mode_i,
    input wire        link_up_i,
    input wire [7:0]  mac_txd_i,
    input wire        mac_tx_en_i,
    input wire        mac_tx_er_i,
    input wire [7:0]  mac_rxd_o,
    input wire        mac_rx_dv_o,
    input wire        mac_rx_er_o,
    input wire [7:0]  line_rxd_i,
    input wire        line_rx_dv_i,
    input wire        line_rx_er_i,
    input wire        line_tx_en_o,
    input wire        connector_loop_o,
    input wire        echo_loop_o,
    input wire        far_end_loop_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    a_read_answer: assert property (mgmt_rd_i |=> mgmt_rvalid_o)
        else $error("read answer missing");
    a_answer_only: assert property (!mgmt_rd_i |=> !mgmt_rvalid_o)
        else $error("read answer without read");
    a_rdata_hold: assert property (!mgmt_rvalid_o |-> $stable(mgmt_rdata_o))
        else $error("read data moved without answer");
    a_lb_quiet: assert property (standard_loopback_bit_i [*2] |-> !line_tx_en_o)
        else $error("line driven in standard loopback");
    a_lb_return: assert property (standard_loopback_bit_i && mac_tx_en_i |=>
        mac_rx_dv_o && mac_rxd_o == $past(mac_txd_i) && mac_rx_er_o == $past(mac_tx_er_i))
        else $error("MAC data not returned");
    a_echo_gigabit: assert property (echo_loop_o |->
        $past(speed_select_high_i) && !$past(speed_select_low_i) && $past(tp_mode_i))
        else $error("echo loop outside gigabit mode");
    a_far_link: assert property (far_end_loop_o |-> $past(link_up_i))
        else $error("far loop with link down");
    a_far_receive: assert property (far_end_loop_o && $past(line_rx_dv_i) &&
        !$past(standard_loopback_bit_i) |-> mac_rx_dv_o &&
        mac_rxd_o == $past(line_rxd_i) && mac_rx_er_o == $past(line_rx_er_i))
        else $error("receive data lost in far loop");
    a_loop_linkup: assert property ($changed(connector_loop_o) |-> $past(link_up_i))
        else $error("loop changed without link");
    c_far: cover property ($rose(far_end_loop_o));
    c_echo: cover property ($rose(echo_loop_o));
    c_conn: cover property ($rose(connector_loop_o));
    c_sat: cover property (mgmt_rvalid_o && mgmt_rdata_o[7:0] == 8'hFF);
endmodule
bind ptlec_top ptlec_monitor u_mon (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .mgmt_rd_i(mgmt_rd_i), .mgmt_rdata_o(mgmt_rdata_o), .mgmt_rvalid_o(mgmt_rvalid_o),
    .standard_loopback_bit_i(standard_loopback_bit_i), .tp_mode_i(tp_mode_i),
    .speed_select_high_i(speed_select_high_i), .speed_select_low_i(speed_select_low_i),
    .link_up_i(link_up_i), .mac_txd_i(mac_txd_i), .mac_tx_en_i(mac_tx_en_i),
    .mac_rxd_o(mac_rxd_o), .mac_rx_dv_o(mac_rx_dv_o), .line_rxd_i(line_rxd_i),
    .line_rx_dv_i(line_rx_dv_i), .line_tx_en_o(line_tx_en_o),
    .connector_loop_o(connector_loop_o), .echo_loop_o(echo_loop_o),
    .far_end_loop_o(far_end_loop_o), .mac_tx_er_i(mac_tx_er_i),
    .mac_rx_er_o(mac_rx_er_o), .line_rx_er_i(line_rx_er_i));

/* File: sim/ptlec_mac_model.sv */
// Behavioural MAC feeding the transmit side of the block
`timescale 1ns/1ps
module ptlec_mac_model (
    input  wire       clk_sys_i,
    input  wire       send_i,
    output reg  [7:0] mac_txd_o,
    output reg        mac_tx_en_o,
    output reg        mac_tx_er_o
);
    reg [7:0] seq_reg = 8'h00;
    initial begin
        mac_txd_o = 8'h00;
        mac_tx_en_o = 1'b0;
        mac_tx_er_o = 1'b0;
    end
    always @(posedge clk_sys_i) begin
        seq_reg <= seq_reg + 8'h01;
        mac_tx_en_o <= send_i;
        mac_tx_er_o <= 1'b0;
        // Idle MAC keeps toggling data so a leak shows on the line
        mac_txd_o <= send_i ? seq_reg : ~mac_txd_o;
    end
endmodule

/* File: sim/ptlec_top_test.sv */
// Self-checking bench of the test loop and error tally block
`timescale 1ns/1ps
`include "ptlec_map.vh"
`define CHK(n, e, g) begin compares = compares + 1; if ((g) !== (e)) begin \
    err_count = err_count + 1; $display("Error %s exp %h got %h", n, e, g); end end
module ptlec_top_test;
    reg        clk = 0, rst = 1, wr_s = 0, rd_s = 0, lb = 0, ssh = 0, speed_select_low = 0;
    reg        tp = 0, link = 0, rxdv = 0, rdy = 1, send = 0, tf_chk = 0, rrdy = 0;
    reg [4:0]  addr = 5'h00;
    reg [15:0] wd = 16'h0000;
    reg [7:0]  ev = 8'h00, rxd = 8'h00;
    wire [15:0] rdata;
    wire [7:0] mrxd, ltxd, txd;
    wire       rvalid, mrxdv, mrxer, lten, lter, cl, el, fl, ml, txen, txer;
    integer    err_count = 0, compares = 0, seed = 32'hd8266354, i, k;
    reg [15:0] rq[$];
    reg [7:0]  tq[$];
    reg [15:0] cont;
    reg [15:0] exp_w;
    reg [7:0]  exp_b;
    reg        rxer = 0;
    ptlec_mac_model mac (.clk_sys_i(clk), .send_i(send), .mac_txd_o(txd),
        .mac_tx_en_o(txen), .mac_tx_er_o(txer));
    ptlec_top dut (.clk_sys_i(clk), .rst_i(rst), .mgmt_addr_i(addr), .mgmt_wr_i(wr_s),
        .mgmt_rd_i(rd_s), .mgmt_wdata_i(wd), .mgmt_rdata_o(rdata), .mgmt_rvalid_o(rvalid),
        .standard_loopback_bit_i(lb), .speed_select_high_i(ssh), .speed_select_low_i(speed_select_low),
        .tp_mode_i(tp), .link_up_i(link), .err_event_i(ev), .mac_txd_i(txd),
        .mac_tx_en_i(txen), .mac_tx_er_i(txer), .mac_rxd_o(mrxd), .mac_rx_dv_o(mrxdv),
        .mac_rx_er_o(mrxer), .line_rxd_i(rxd), .line_rx_dv_i(rxdv), .line_rx_er_i(rxer),
        .line_txd_o(ltxd), .line_tx_en_o(lten), .line_tx_er_o(lter),
        .line_tx_ready_i(rdy), .connector_loop_o(cl), .echo_loop_o(el),
        .far_end_loop_o(fl), .mac_loop_o(ml));
    always #5 clk = ~clk;
    task summarize;
        begin
            $display("errors %0d compares %0d", err_count, compares);
            if (err_count == 0 && compares > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    task wr(input [4:0] a, input [15:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wd <= d;
            wr_s <= 1'b1;
            @(posedge clk);
            wr_s <= 1'b0;
        end
    endtask
    task rd(input [4:0] a, input [15:0] e);
        begin
            @(posedge clk);
            addr <= a;
            rd_s <= 1'b1;
            rq.push_back(e);
            @(posedge clk);
            rd_s <= 1'b0;
            @(posedge clk);
        end
    endtask
    // Exactly n events on the chosen bit, noise on all the others
    task evn(input [7:0] m, input integer n);
        begin
            repeat (n) begin
                @(posedge clk);
                ev <= ($random(seed) & ~m) | m;
                @(posedge clk);
                ev <= $random(seed) & ~m;
            end
            @(posedge clk);
            ev <= 8'h00;
        end
    endtask
    task lnk;
        begin
            @(posedge clk);
            link <= 1'b0;
            repeat (3) @(posedge clk);
            link <= 1'b1;
            repeat (4) @(posedge clk);
        end
    endtask
    always @(posedge clk) begin
        rxd <= $random(seed);
        rxdv <= $random(seed);
        rxer <= $random(seed);
        if (rrdy)
            rdy <= $random(seed);
        // Pop once; the check macro names its expected value twice
        if (rvalid === 1'b1) begin
            exp_w = rq.pop_front();
            `CHK("mgmt_rdata", exp_w, rdata)
        end
        // Each cycle with enable high carries one popped entry, whatever ready is now
        if (tf_chk && lten === 1'b1 && tq.size() > 0) begin
            exp_b = tq.pop_front();
            `CHK("line_txd", exp_b, ltxd)
            `CHK("line_tx_er", 1'b0, lter)
        end
    end
    initial begin
        repeat (60000) @(posedge clk);
        err_count = err_count + 1;
        summarize;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(`PTLEC_ADDR_CTRL_ONE, `PTLEC_RST_WORD);
        rd(`PTLEC_ADDR_ERR_TALLY, `PTLEC_RST_WORD);
        rd(`PTLEC_ADDR_TF_CONTROL, {`PTLEC_RST_LEN, 8'h00});
        rd(`PTLEC_ADDR_TF_CONTENT, `PTLEC_RST_CONTENT);
        rd(5'h01, 16'h0000);
        cont = $random(seed);
        wr(`PTLEC_ADDR_TF_CONTENT, cont);
        rd(`PTLEC_ADDR_TF_CONTENT, cont);
        tp <= 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            // Count bits are read-only, so writing ones must not preset them
            wr(`PTLEC_ADDR_ERR_TALLY, {5'h00, i[2:0], 8'hFF});
            evn(8'h01 << i, i + 3);
            rd(`PTLEC_ADDR_ERR_TALLY, {5'h00, i[2:0], i[7:0] + 8'h03});
            rd(`PTLEC_ADDR_ERR_TALLY, {5'h00, i[2:0], 8'h00});
        end
        wr(`PTLEC_ADDR_ERR_TALLY, 16'h0000);
        evn(8'h01, 260);
        rd(`PTLEC_ADDR_ERR_TALLY, {8'h00, `PTLEC_COUNT_MAX});
        tp <= 1'b0;
        evn(8'h01, 5);
        rd(`PTLEC_ADDR_ERR_TALLY, 16'h0000);
        tp <= 1'b1;
        link <= 1'b1;
        ssh <= 1'b1;
        send <= 1'b1;
        wr(`PTLEC_ADDR_CTRL_ONE, {13'h0000, `PTLEC_LOOP_NEAR});
        repeat (6) @(posedge clk);
        `CHK("mac_loop", 1'b0, ml)
        for (i = 0; i < 5; i = i + 1) begin
            wr(`PTLEC_ADDR_CTRL_ONE, i[15:0]);
            rd(`PTLEC_ADDR_CTRL_ONE, i[15:0]);
            lnk;
            `CHK("mac_loop", i == `PTLEC_LOOP_NEAR, ml)
            `CHK("conn_loop", i == `PTLEC_LOOP_CONNECTOR, cl)
            `CHK("echo_loop", i == `PTLEC_LOOP_ECHO, el)
            `CHK("far_loop", i == `PTLEC_LOOP_FAR, fl)
            if (i == `PTLEC_LOOP_ECHO) begin
                speed_select_low <= 1'b1;
                repeat (2) @(posedge clk);
                `CHK("echo_loop", 1'b0, el)
                speed_select_low <= 1'b0;
            end
        end
        link <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK("far_loop", 1'b0, fl)
        wr(`PTLEC_ADDR_CTRL_ONE, 16'h0000);
        lnk;
        lb <= 1'b1;
        repeat (20) @(posedge clk);
        `CHK("line_tx_en", 1'b0, lten)
        lb <= 1'b0;
        send <= 1'b0;
        repeat (10) @(posedge clk);
        for (k = 0; k < 7; k = k + 1)
            tq.push_back(`PTLEC_PREAMBLE_OCTET);
        tq.push_back(`PTLEC_SFD_OCTET);
        tq.push_back(cont[7:0]);
        tq.push_back(cont[15:8]);
        tf_chk <= 1'b1;
        rrdy <= 1'b1;
        wr(`PTLEC_ADDR_TF_CONTROL, 16'h0201);
        for (k = 0; k < 3000 && tq.size() > 0; k = k + 1)
            @(posedge clk);
        `CHK("frame_left", 0, tq.size())
        tf_chk <= 1'b0;
        wr(`PTLEC_ADDR_TF_CONTROL, 16'h0000);
        summarize;
    end
endmodule
